// ### core/iar_regs.sv
/*
 * Register bank of the subscriber-access controller as an APB slave:
 * shared FIFO window, split read/write decoding, reset values, frame-select
 * pin control and configuration outputs for the HDLC and layer-1 logic.
 * Assumes the receive byte stream and indication inputs come from logic on
 * clk_i; pin-like inputs are synchronised here.
 */
module iar_regs #(
	parameter int DEPTH = iar_pkg::FIFO_DEPTH
) (
	input  wire logic                  clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [9:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire iar_pkg::iar_rx_byte_s rx_byte_i,
	input  wire logic [7:0]            rx_status_i,
	input  wire logic [7:0]            rx_control_i,
	input  wire logic [7:0]            rx_sapi_i,
	input  wire logic [3:0]            indication_code_i,
	input  wire logic                  awake_detect_i,
	input  wire logic                  watchdog_expire_i,
	output logic                       frame_select_output_o,
	output logic                       data_port_one_pin_o,
	output logic                       tx_write_o,
	output logic      [7:0]            tx_data_o,
	output logic                       cmd_write_o,
	output logic      [7:0]            cmd_data_o,
	output logic                       internal_reset_o,
	output iar_pkg::iar_cfg_s          cfg_o
);

	localparam int PW      = $clog2(DEPTH);
	localparam int COUNT_W = iar_pkg::COUNT_WIDTH;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]       mode;
		logic [7:0]       timer;
		logic [7:0]       serial_port_control;
		logic [7:0]       cix;
		logic [7:0]       sync_transfer_control;
		logic [7:0]       feature_config_first;
		logic [7:0]       feature_config_second;
		logic [7:0]       sq_channel_transmit;
		logic [7:0]       individual_sapi_first;
		logic [7:0]       individual_sapi_second;
		logic [7:0]       individual_tei_first;
		logic [7:0]       individual_tei_second;
		logic [7:0]       transmit_address_first;
		logic [7:0]       transmit_address_second;
		logic [7:0]       cir;
		logic [3:0]       code_prev;
		logic             serial_port_control_written;
		logic [PW-1:0]    wr_ptr;
		logic [PW-1:0]    rd_ptr;
		logic [COUNT_W-1:0] count;
		logic             overflow;
		logic [1:0]       awake_sync;
		logic [1:0]       wdog_sync;
		logic             int_reset;
		logic [31:0]      rdata;
		logic             tx_write;
		logic             cmd_write;
		logic [7:0]       wdata;
	} iar_state_s;

	iar_state_s state_r;
	iar_state_s state_nxt;
	logic [7:0] rx_mem_r [DEPTH];

	logic       access;
	logic       wr;
	logic       rd;
	logic [7:0] idx;
	logic [7:0] wd;
	logic [7:0] rval;

	assign access = psel_i & penable_i;
	assign wr     = access & pwrite_i;
	assign rd     = access & ~pwrite_i;
	assign idx    = paddr_i[9:2];
	assign wd     = pwdata_i[7:0];

	// ----------------------------------------------------------------
	// receive store
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rx_byte_i.valid) begin
			rx_mem_r[state_r.wr_ptr] <= rx_byte_i.data;
		end
	end

	// ----------------------------------------------------------------
	// read mux: read side of each shared offset
	// ----------------------------------------------------------------
	always_comb begin
		rval = iar_pkg::UNMAPPED_READ;
		if (idx <= iar_pkg::IDX_FIFO_LAST) begin
			rval = rx_mem_r[state_r.rd_ptr];
		end else begin
			unique case (idx)
				iar_pkg::IDX_COUNT_LOW:      rval = state_r.count[7:0];
				iar_pkg::IDX_COUNT_HIGH:     rval = {3'h0, state_r.overflow,
					state_r.count[11:8]};
				iar_pkg::IDX_HDLC_STATUS:    rval = iar_pkg::RST_HDLC_STATUS;
				iar_pkg::IDX_MODE:           rval = state_r.mode;
				iar_pkg::IDX_TIMER:          rval = state_r.timer;
				iar_pkg::IDX_SAPI:           rval = rx_sapi_i;
				iar_pkg::IDX_RX_STATUS:      rval = rx_status_i;
				iar_pkg::IDX_TEI_SECOND:     rval = rx_control_i;
				iar_pkg::IDX_SERIAL_CTRL:    rval = state_r.serial_port_control;
				iar_pkg::IDX_INDICATION:     rval = state_r.cir;
				iar_pkg::IDX_FEATURE_SECOND: rval = state_r.feature_config_second;
				default:                     rval = iar_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt           = state_r;
		state_nxt.tx_write  = 1'b0;
		state_nxt.cmd_write = 1'b0;
		state_nxt.wdata     = wd;
		state_nxt.awake_sync = {state_r.awake_sync[0], awake_detect_i};
		state_nxt.wdog_sync  = {state_r.wdog_sync[0], watchdog_expire_i};

		// received bytes, count and pointer
		if (rx_byte_i.valid) begin
			state_nxt.wr_ptr = state_r.wr_ptr + 1'b1;
			{state_nxt.overflow, state_nxt.count} =
				{1'b0, state_r.count} + {{COUNT_W{1'b0}}, 1'b1};
			state_nxt.overflow = state_nxt.overflow | state_r.overflow;
		end

		// indication: code change flag set on a new code
		state_nxt.cir[5:2] = indication_code_i;
		if (indication_code_i != state_r.code_prev) begin
			state_nxt.cir[1] = 1'b1;
		end
		state_nxt.code_prev = indication_code_i;

		if (rd) begin
			state_nxt.rdata = {24'h0, rval};
			if (idx <= iar_pkg::IDX_FIFO_LAST) begin
				state_nxt.rd_ptr = state_r.rd_ptr + 1'b1;
			end
			if (idx == iar_pkg::IDX_INDICATION &&
				indication_code_i == state_r.code_prev) begin
				state_nxt.cir[1] = 1'b0;
			end
		end

		if (wr) begin
			if (idx <= iar_pkg::IDX_FIFO_LAST) begin
				state_nxt.tx_write = 1'b1;
			end else begin
				unique case (idx)
					iar_pkg::IDX_HDLC_STATUS: begin
						state_nxt.cmd_write = 1'b1;
						if (wd[7]) begin
							state_nxt.count    = '0;
							// a coincident wrap outlives the clear
							state_nxt.overflow = rx_byte_i.valid & (&state_r.count);
							state_nxt.rd_ptr   = '0;
							state_nxt.wr_ptr   = '0;
						end
					end
					iar_pkg::IDX_MODE:           state_nxt.mode = wd;
					iar_pkg::IDX_TIMER:          state_nxt.timer = wd;
					iar_pkg::IDX_EXT_STATUS:     state_nxt.transmit_address_first = wd;
					iar_pkg::IDX_COUNT_LOW:      state_nxt.transmit_address_second = wd;
					iar_pkg::IDX_SAPI:           state_nxt.individual_sapi_first = wd;
					iar_pkg::IDX_RX_STATUS:      state_nxt.individual_sapi_second = wd;
					iar_pkg::IDX_TEI_FIRST:      state_nxt.individual_tei_first = wd;
					iar_pkg::IDX_TEI_SECOND:     state_nxt.individual_tei_second = wd;
					iar_pkg::IDX_SERIAL_CTRL: begin
						state_nxt.serial_port_control         = wd;
						state_nxt.serial_port_control_written = 1'b1;
					end
					iar_pkg::IDX_INDICATION:     state_nxt.cix = wd;
					iar_pkg::IDX_SYNC_CTRL:      state_nxt.sync_transfer_control = wd;
					iar_pkg::IDX_FEATURE_FIRST:  state_nxt.feature_config_first = wd;
					iar_pkg::IDX_FEATURE_SECOND: state_nxt.feature_config_second = wd;
					iar_pkg::IDX_SQ_CHANNEL:     state_nxt.sq_channel_transmit = wd;
					default: ;
				endcase
			end
		end

		// internal reset source, only with terminal functions enabled
		state_nxt.int_reset = state_r.sync_transfer_control[iar_pkg::SYNC_TRANSFER_CONTROL_TSF_BIT] &
			(state_r.cix[iar_pkg::CIX_RSS_BIT] ? state_r.wdog_sync[1]
			                                    : state_r.awake_sync[1]);

		if (!rstn_i) begin
			state_nxt              = '0;
			state_nxt.mode         = iar_pkg::RST_ZERO;
			state_nxt.count        = '0;
			state_nxt.cir          = iar_pkg::RST_INDICATION;
			state_nxt.code_prev    = iar_pkg::RST_INDICATION[5:2];
			state_nxt.cix          = iar_pkg::RST_COMMAND;
			state_nxt.sync_transfer_control         = iar_pkg::RST_ZERO;
			state_nxt.feature_config_first         = iar_pkg::RST_ZERO;
			state_nxt.serial_port_control         = iar_pkg::RST_ZERO;
			state_nxt.sq_channel_transmit         = iar_pkg::RST_SQ_CHANNEL;
			state_nxt.feature_config_second         = iar_pkg::RST_ZERO;
			state_nxt.serial_port_control_written = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		state_r <= state_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pready_o   = 1'b1;
	assign pslverr_o  = 1'b0;
	assign prdata_o   = rd ? {24'h0, rval} : state_r.rdata;
	assign tx_write_o = state_r.tx_write;
	assign tx_data_o  = state_r.wdata;
	assign cmd_write_o = state_r.cmd_write;
	assign cmd_data_o  = state_r.wdata;
	assign internal_reset_o = state_r.int_reset;

	// frame-select low until first serial control write; then mode driven
	assign frame_select_output_o = state_r.serial_port_control_written &
		(state_r.feature_config_second[iar_pkg::FEATURE_CONFIG_SECOND_IMS_BIT] ? |state_r.feature_config_second[2:0]
		                                     : state_r.serial_port_control[iar_pkg::SERIAL_PORT_CONTROL_TLP_BIT]);
	assign data_port_one_pin_o = 1'b1;

	always_comb begin
		cfg_o = '0;
		cfg_o.message_transfer_mode = state_r.mode[7:5];
		cfg_o.internal_timer_select = state_r.mode[iar_pkg::MODE_TMD_BIT];
		cfg_o.receiver_active       = state_r.mode[iar_pkg::MODE_RAC_BIT];
		cfg_o.arbitration_mode      = state_r.mode[2:0];
		cfg_o.timer_count_field     = state_r.timer[7:5];
		cfg_o.timer_value           = state_r.timer[4:0];
		cfg_o.standby_clock_request = state_r.serial_port_control[iar_pkg::SERIAL_PORT_CONTROL_SPU_BIT];
		cfg_o.interface_test_loop   = state_r.serial_port_control[iar_pkg::SERIAL_PORT_CONTROL_TLP_BIT];
		cfg_o.channel_one_connect   = state_r.serial_port_control[3:2];
		cfg_o.channel_two_connect   = state_r.serial_port_control[1:0];
		cfg_o.terminal_function_enable = state_r.sync_transfer_control[iar_pkg::SYNC_TRANSFER_CONTROL_TSF_BIT];
		cfg_o.reset_from_watchdog   = state_r.sync_transfer_control[iar_pkg::SYNC_TRANSFER_CONTROL_TSF_BIT] &
			state_r.cix[iar_pkg::CIX_RSS_BIT];
		cfg_o.reset_from_awake      = state_r.sync_transfer_control[iar_pkg::SYNC_TRANSFER_CONTROL_TSF_BIT] &
			~state_r.cix[iar_pkg::CIX_RSS_BIT];
		cfg_o.shared_bus_address    = state_r.sync_transfer_control[6:4];
		cfg_o.command_code          = state_r.cix[5:2];
		cfg_o.shared_bus_request    = state_r.cix[iar_pkg::CIX_BAC_BIT];
		cfg_o.test_mode_bit         = state_r.feature_config_first[iar_pkg::FEATURE_CONFIG_FIRST_TEM_BIT];
		cfg_o.prefilter_enable      = state_r.feature_config_first[iar_pkg::FEATURE_CONFIG_FIRST_PFS_BIT];
		cfg_o.interface_off_switch  = state_r.feature_config_first[iar_pkg::FEATURE_CONFIG_FIRST_IOF_BIT];
		cfg_o.flag_fill             = state_r.feature_config_first[iar_pkg::FEATURE_CONFIG_FIRST_ITF_BIT];
		cfg_o.interface_mode_select = state_r.feature_config_second[iar_pkg::FEATURE_CONFIG_SECOND_IMS_BIT];
		cfg_o.output_driver_select  = state_r.feature_config_second[iar_pkg::FEATURE_CONFIG_SECOND_ODS_BIT];
		cfg_o.data_port_direction   = state_r.sq_channel_transmit[iar_pkg::SQ_CHANNEL_TRANSMIT_IDC_BIT];
		cfg_o.power_down_enable     = state_r.sq_channel_transmit[iar_pkg::SQ_CHANNEL_TRANSMIT_CFS_BIT];
		cfg_o.sq_interrupt_enable   = state_r.sq_channel_transmit[iar_pkg::SQ_CHANNEL_TRANSMIT_SQIE_BIT];
		cfg_o.permanent_standby     = ~state_r.sq_channel_transmit[iar_pkg::SQ_CHANNEL_TRANSMIT_CFS_BIT];
		cfg_o.standby_request       = state_r.serial_port_control[iar_pkg::SERIAL_PORT_CONTROL_SPU_BIT] &
			state_r.sq_channel_transmit[iar_pkg::SQ_CHANNEL_TRANSMIT_CFS_BIT];
		cfg_o.sapi_first            = state_r.individual_sapi_first;
		cfg_o.sapi_second           = state_r.individual_sapi_second;
		cfg_o.tei_first             = state_r.individual_tei_first;
		cfg_o.tei_second            = state_r.individual_tei_second;
		cfg_o.tx_address_first      = state_r.transmit_address_first;
		cfg_o.tx_address_second     = state_r.transmit_address_second;
	end

endmodule

// ### core/iar_pkg.sv
/*
 * Package for the subscriber-access register bank: offsets, reset values,
 * field positions and the packed structs that carry bus and core signals.
 * Assumes an APB master with 32-bit data; each register takes one word,
 * byte address = 4 * register index.
 */
package iar_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_FIFO_LAST      = 8'h1f;
	localparam logic [7:0] IDX_INT_STATUS     = 8'h20;
	localparam logic [7:0] IDX_HDLC_STATUS    = 8'h21;
	localparam logic [7:0] IDX_MODE           = 8'h22;
	localparam logic [7:0] IDX_TIMER          = 8'h23;
	localparam logic [7:0] IDX_EXT_STATUS     = 8'h24;
	localparam logic [7:0] IDX_COUNT_LOW      = 8'h25;
	localparam logic [7:0] IDX_SAPI           = 8'h26;
	localparam logic [7:0] IDX_RX_STATUS      = 8'h27;
	localparam logic [7:0] IDX_TEI_FIRST      = 8'h28;
	localparam logic [7:0] IDX_TEI_SECOND     = 8'h29;
	localparam logic [7:0] IDX_COUNT_HIGH     = 8'h2a;
	localparam logic [7:0] IDX_STATUS_SECOND  = 8'h2b;
	localparam logic [7:0] IDX_SERIAL_CTRL    = 8'h30;
	localparam logic [7:0] IDX_INDICATION     = 8'h31;
	localparam logic [7:0] IDX_SYNC_CTRL      = 8'h37;
	localparam logic [7:0] IDX_FEATURE_FIRST  = 8'h38;
	localparam logic [7:0] IDX_FEATURE_SECOND = 8'h39;
	localparam logic [7:0] IDX_SQ_CHANNEL     = 8'h3b;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam logic [7:0] RST_INDICATION  = 8'h7c;
	localparam logic [7:0] RST_COMMAND     = 8'h3c;
	localparam logic [7:0] RST_SQ_CHANNEL  = 8'h00;
	localparam logic [7:0] RST_HDLC_STATUS = 8'h48;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MODE_MDS_LSB   = 5;
	localparam int MODE_TMD_BIT   = 4;
	localparam int MODE_RAC_BIT   = 3;
	localparam int MODE_DIM_LSB   = 0;
	localparam int LINK_TIMER_CONFIG_CNT_LSB   = 5;
	localparam int SERIAL_PORT_CONTROL_SPU_BIT   = 7;
	localparam int SERIAL_PORT_CONTROL_TLP_BIT   = 4;
	localparam int SERIAL_PORT_CONTROL_C1C_LSB   = 2;
	localparam int SERIAL_PORT_CONTROL_C2C_LSB   = 0;
	localparam int CIX_RSS_BIT    = 7;
	localparam int CIX_BAC_BIT    = 6;
	localparam int CIX_COD_LSB    = 2;
	localparam int SYNC_TRANSFER_CONTROL_TSF_BIT   = 7;
	localparam int SYNC_TRANSFER_CONTROL_TBA_LSB   = 4;
	localparam int SYNC_TRANSFER_CONTROL_ST_LSB    = 2;
	localparam int FEATURE_CONFIG_FIRST_TEM_BIT   = 5;
	localparam int FEATURE_CONFIG_FIRST_PFS_BIT   = 4;
	localparam int FEATURE_CONFIG_FIRST_IOF_BIT   = 3;
	localparam int FEATURE_CONFIG_FIRST_ITF_BIT   = 0;
	localparam int FEATURE_CONFIG_SECOND_IMS_BIT   = 7;
	localparam int FEATURE_CONFIG_SECOND_ODS_BIT   = 3;
	localparam int FEATURE_CONFIG_SECOND_D1C_LSB   = 0;
	localparam int SQ_CHANNEL_TRANSMIT_IDC_BIT   = 7;
	localparam int SQ_CHANNEL_TRANSMIT_CFS_BIT   = 6;
	localparam int SQ_CHANNEL_TRANSMIT_SQIE_BIT  = 4;
	localparam int RECEIVE_COUNT_HIGH_OV_BIT    = 4;

	localparam int FIFO_DEPTH     = 32;
	localparam int COUNT_WIDTH    = 12;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} iar_apb_req_s;

	typedef struct packed {
		logic [2:0] message_transfer_mode;
		logic       internal_timer_select;
		logic       receiver_active;
		logic [2:0] arbitration_mode;
		logic [2:0] timer_count_field;
		logic [4:0] timer_value;
		logic       standby_clock_request;
		logic       interface_test_loop;
		logic [1:0] channel_one_connect;
		logic [1:0] channel_two_connect;
		logic       terminal_function_enable;
		logic       reset_from_watchdog;
		logic       reset_from_awake;
		logic [2:0] shared_bus_address;
		logic [3:0] command_code;
		logic       shared_bus_request;
		logic       test_mode_bit;
		logic       prefilter_enable;
		logic       interface_off_switch;
		logic       flag_fill;
		logic       interface_mode_select;
		logic       output_driver_select;
		logic       data_port_direction;
		logic       power_down_enable;
		logic       sq_interrupt_enable;
		logic       permanent_standby;
		logic       standby_request;
		logic [7:0] sapi_first;
		logic [7:0] sapi_second;
		logic [7:0] tei_first;
		logic [7:0] tei_second;
		logic [7:0] tx_address_first;
		logic [7:0] tx_address_second;
	} iar_cfg_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       frame_end;
	} iar_rx_byte_s;

endpackage

// ### test/iar_regs_sva.sv
/*
 * Checker for the register bank: access handshake, side pulses, read decode,
 * frame-select hold and reset state.
 * Assumes it is bound to iar_regs and sees only that module's ports.
 */
module iar_regs_sva #(
	parameter int DEPTH = 32
) (
	input wire logic              clk_i,
	input wire logic              rstn_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic              pwrite_i,
	input wire logic [9:0]        paddr_i,
	input wire logic [31:0]       pwdata_i,
	input wire logic [31:0]       prdata_o,
	input wire logic              pready_o,
	input wire logic              pslverr_o,
	input wire logic              frame_select_output_o,
	input wire logic              data_port_one_pin_o,
	input wire logic              tx_write_o,
	input wire logic [7:0]        tx_data_o,
	input wire logic              cmd_write_o,
	input wire logic [7:0]        cmd_data_o,
	input wire logic              internal_reset_o,
	input wire iar_pkg::iar_cfg_s cfg_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	logic       wacc;
	logic       racc;
	logic       serial_port_control_seen_r;
	logic [7:0] idx;
	logic [7:0] wbyte;
	assign idx   = paddr_i[9:2];
	assign wbyte = pwdata_i[7:0];
	assign wacc  = psel_i && penable_i && pwrite_i;
	assign racc  = psel_i && penable_i && !pwrite_i;

	// ----------------------------------------------------------------
	// first serial control write seen
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			serial_port_control_seen_r <= 1'b0;
		else if (wacc && idx == 8'h30)
			serial_port_control_seen_r <= 1'b1;
	end

	a_access_ready: assert property (psel_i && penable_i |-> pready_o && !pslverr_o)
		else $error("access not answered cleanly");
	a_fifo_push: assert property (wacc && idx <= 8'h1f |=>
		tx_write_o && tx_data_o == $past(wbyte))
		else $error("fifo write pulse wrong");
	a_fifo_only: assert property (tx_write_o |-> $past(wacc) && $past(idx) <= 8'h1f)
		else $error("spurious fifo pulse");
	a_cmd_push: assert property (wacc && idx == 8'h21 |=>
		cmd_write_o && cmd_data_o == $past(wbyte))
		else $error("command pulse wrong");
	a_read_upper: assert property (racc |-> prdata_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_status_read: assert property (racc && idx == 8'h21 |-> prdata_o == 32'h48)
		else $error("status read wrong");
	a_hole_read: assert property (racc && (idx == 8'h28 || idx > 8'h3b) |->
		prdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_select_low: assert property (!serial_port_control_seen_r |-> !frame_select_output_o)
		else $error("frame select high before first write");
	a_reset_state: assert property ($rose(rstn_i) |-> cfg_o.command_code == 4'hf
		&& !cfg_o.sq_interrupt_enable && !cfg_o.interface_mode_select && !frame_select_output_o)
		else $error("reset state wrong");
	a_gate_reset: assert property (!cfg_o.terminal_function_enable [*3] |-> !internal_reset_o)
		else $error("internal reset without terminal functions");
	a_port_pin: assert property (data_port_one_pin_o)
		else $error("data port pin low");

	c_fifo_write: cover property (wacc && idx <= 8'h1f);
	c_fifo_read: cover property (racc && idx <= 8'h1f);
	c_serial_port_control_write: cover property (wacc && idx == 8'h30);
endmodule

bind iar_regs iar_regs_sva #(.DEPTH(DEPTH)) u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.frame_select_output_o(frame_select_output_o), .data_port_one_pin_o(data_port_one_pin_o),
	.tx_write_o(tx_write_o), .tx_data_o(tx_data_o), .cmd_write_o(cmd_write_o),
	.cmd_data_o(cmd_data_o), .internal_reset_o(internal_reset_o), .cfg_o(cfg_o));

// ### test/iar_host.sv
/*
 * Microcontroller model: an APB master with one transfer task.
 * Assumes a slave answering with pready; waits are cut by the bench.
 */
module iar_host (
	input  wire logic        clk_i,
	input  wire logic        pready_i,
	input  wire logic [31:0] prdata_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [9:0]  paddr_o,
	output logic      [31:0] pwdata_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 10'h0;
		pwdata_o = 32'h0;
	end

	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= {idx, 2'b00};
		pwdata_o <= {24'h0, (idx == 8'h3b) ? (d & 8'h7f) : d};
		@(posedge clk_i);
		penable_o <= 1'b1;
		@(posedge clk_i);
		while (pready_i !== 1'b1) @(posedge clk_i);
		q = prdata_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~paddr_o;
		pwdata_o <= ~pwdata_o;
	endtask
endmodule

// ### test/testbench.sv
/*
 * Self-checking bench for the register bank.
 * Assumes the host model for bus traffic; receive bytes driven here.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic                  clk_i = 1'b0;
	logic                  rstn_i = 1'b0;
	logic                  psel, penable, pwrite, pready, awake, fsel, dport, txw, cmdw, irst, r1;
	logic                  wdog;
	logic [9:0]            paddr;
	logic [31:0]           pwdata, prdata, q;
	logic [7:0]            txd, cmdd;
	logic [3:0]            ind_code = 4'hf;
	iar_pkg::iar_rx_byte_s rx_byte = '0;
	iar_pkg::iar_cfg_s     cfg;
	logic [7:0]            ridx [6] = '{8'h22, 8'h23, 8'h25, 8'h30, 8'h31, 8'h39};
	logic [7:0]            rexp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7c, 8'h89};
	int                    failures = 0;
	int                    n_tests = 0;

	always #25 clk_i = ~clk_i;
	initial {awake, wdog} = 2'b00;

	iar_host host (.clk_i(clk_i), .pready_i(pready), .prdata_i(prdata), .psel_o(psel),
		.penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

	iar_regs dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(), .rx_byte_i(rx_byte), .rx_status_i(8'h11),
		.rx_control_i(8'h22), .rx_sapi_i(8'h96), .indication_code_i(ind_code),
		.awake_detect_i(awake), .watchdog_expire_i(wdog), .frame_select_output_o(fsel),
		.data_port_one_pin_o(dport), .tx_write_o(txw), .tx_data_o(txd), .cmd_write_o(cmdw),
		.cmd_data_o(cmdd), .internal_reset_o(irst), .cfg_o(cfg));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		host.xfer(1'b1, idx, d, q);
	endtask

	task automatic rdm(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
		host.xfer(1'b0, idx, 8'h00, q);
		chk($sformatf("reg %h", idx), {24'h0, exp}, q & {24'hffffff, m});
	endtask

	task automatic settle;
		repeat (4) @(posedge clk_i);
		#1;
	endtask

	task automatic push(input logic [7:0] b);
		@(posedge clk_i);
		rx_byte <= '{1'b1, b, 1'b0};
		@(posedge clk_i);
		rx_byte <= '{1'b0, ~b, 1'b0};
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		#1;
		chk("select pin", 1'b0, fsel);
		chk("port pin", 1'b1, dport);
		chk("cmd code", 5'h1e, {cfg.command_code, cfg.shared_bus_request});
		chk("sync", 4'h0, {cfg.terminal_function_enable, cfg.shared_bus_address});
		chk("feature", 4'h0, {cfg.test_mode_bit, cfg.prefilter_enable, cfg.flag_fill,
			cfg.interface_off_switch});
		chk("sq ie", 1'b0, cfg.sq_interrupt_enable);
		wr(8'h39, 8'h89);
		settle();
		chk("select held", 3'h3, {fsel, cfg.interface_mode_select,
			cfg.output_driver_select});
		for (int i = 0; i < 6; i++) rdm(ridx[i], 8'hff, rexp[i]);
		rdm(8'h2a, 8'h1f, 8'h00);
		wr(8'h30, 8'h80);
		settle();
		chk("select pin", 1'b1, fsel);
		rdm(8'h30, 8'hff, 8'h80);
		wr(8'h3b, 8'hd0);
		settle();
		chk("sq cfg", 5'h0d, {cfg.data_port_direction, cfg.power_down_enable,
			cfg.sq_interrupt_enable, cfg.permanent_standby,
			cfg.standby_request});
		wr(8'h3b, 8'h00);
		settle();
		chk("perm standby", 1'b1, cfg.permanent_standby);
		wr(8'h22, 8'hb5);
		wr(8'h23, 8'h6a);
		rdm(8'h22, 8'hff, 8'hb5);
		rdm(8'h23, 8'hff, 8'h6a);
		chk("mode", 8'hb5, {cfg.message_transfer_mode, cfg.internal_timer_select,
			cfg.receiver_active, cfg.arbitration_mode});
		chk("timer", 8'h6a, {cfg.timer_count_field, cfg.timer_value});
		@(posedge clk_i) {awake, wdog} <= 2'b11;
		wr(8'h31, 8'h80);
		settle();
		chk("gated reset", 1'b0, irst);
		wr(8'h37, 8'hd0);
		settle();
		chk("watchdog source", 1'b1, irst);
		@(posedge clk_i) wdog <= 1'b0;
		settle();
		r1 = irst;
		wr(8'h31, 8'h00);
		settle();
		chk("reset source", 1'b1, r1 ^ irst);
		chk("cix sync", 9'h085, {cfg.reset_from_watchdog, cfg.reset_from_awake,
			cfg.command_code, cfg.shared_bus_address});
		wr(8'h37, 8'h00);
		@(posedge clk_i) awake <= 1'b0;
		push(8'ha1);
		push(8'hb2);
		push(8'hc3);
		rdm(8'h25, 8'hff, 8'h03);
		rdm(8'h00, 8'hff, 8'ha1);
		rdm(8'h1f, 8'hff, 8'hb2);
		rdm(8'h07, 8'hff, 8'hc3);
		wr(8'h05, 8'h3e);
		#1;
		chk("tx pulse", 9'h13e, {txw, txd});
		@(posedge clk_i);
		#1;
		chk("tx end", 1'b0, txw);
		wr(8'h21, 8'h01);
		#1;
		chk("cmd pulse", 9'h101, {cmdw, cmdd});
		rdm(8'h21, 8'hff, 8'h48);
		wr(8'h25, 8'h77);
		rdm(8'h25, 8'hff, 8'h03);
		chk("transmit_address_second", 8'h77, cfg.tx_address_second);
		wr(8'h21, 8'h80);
		rdm(8'h25, 8'hff, 8'h00);
		wr(8'h28, 8'h5a);
		wr(8'h26, 8'h3c);
		wr(8'h2a, 8'hff);
		wr(8'h24, 8'h11);
		wr(8'h27, 8'h22);
		wr(8'h29, 8'h33);
		wr(8'h30, 8'h9e);
		wr(8'h38, 8'h39);
		settle();
		chk("tei sapi", 16'h5a3c, {cfg.tei_first, cfg.sapi_first});
		chk("addr second", 24'h112233, {cfg.tx_address_first, cfg.sapi_second,
			cfg.tei_second});
		chk("serial_port_control cfg", 6'h3e, {cfg.standby_clock_request, cfg.interface_test_loop,
			cfg.channel_one_connect, cfg.channel_two_connect});
		chk("feature cfg", 4'hf, {cfg.test_mode_bit, cfg.prefilter_enable, cfg.flag_fill,
			cfg.interface_off_switch});
		rdm(8'h27, 8'hff, 8'h11);
		rdm(8'h29, 8'hff, 8'h22);
		rdm(8'h28, 8'hff, 8'h00);
		rdm(8'h26, 8'hff, 8'h96);
		rdm(8'h2a, 8'h1f, 8'h00);
		rdm(8'hff, 8'hff, 8'h00);
		@(posedge clk_i) ind_code <= 4'h5;
		settle();
		rdm(8'h31, 8'h3e, 8'h16);
		rdm(8'h31, 8'h3e, 8'h14);
		@(posedge clk_i) rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		#1;
		chk("reset again", 5'h0f, {fsel, cfg.command_code});
		summarize();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		summarize();
	end
endmodule
